//--- core/lmis_consts.svh
`ifndef LMIS_CONSTS_SVH
`define LMIS_CONSTS_SVH

// ----------------------------------------------------------------
// Opcode patterns (14-bit instruction words)
// ----------------------------------------------------------------
`define LMIS_OP_NOP        14'h0000
`define LMIS_OP_RESET      14'h0001
`define LMIS_OP_OPTION     14'h0062
`define LMIS_MSK_BANK      14'h3FE0
`define LMIS_PAT_BANK      14'h0020
`define LMIS_MSK_PAGE      14'h3F80
`define LMIS_PAT_PAGE      14'h3180
`define LMIS_MSK_ACCLIT    14'h3F00
`define LMIS_PAT_ACCLIT    14'h3000
`define LMIS_MSK_STFILE    14'h3F80
`define LMIS_PAT_STFILE    14'h0080
`define LMIS_MSK_INDMODE   14'h3FF8
`define LMIS_PAT_INDMODE   14'h0018
`define LMIS_MSK_INDREL    14'h3F80
`define LMIS_PAT_INDREL    14'h3F80

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LMIS_SEL_MODE_BIT  2
`define LMIS_SEL_REL_BIT   6
`define LMIS_FILE_IND0     7'h00
`define LMIS_FILE_IND1     7'h01

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LMIS_RST_ACC       8'h00
`define LMIS_RST_BANK      5'h00
`define LMIS_RST_PAGE      7'h00
`define LMIS_RST_OPTION    8'hFF
`define LMIS_RST_PTR       16'h0000
`define LMIS_RST_STATUS    3'h0
`define LMIS_RST_SWFLAG    1'b1
`define LMIS_RST_PULSE     1'b0

`endif

//--- core/lmis_pkg.sv
package lmis_pkg;

    // Decoded instruction class
    typedef enum {
        LMIS_I_NOP,
        LMIS_I_BANK,
        LMIS_I_PAGE,
        LMIS_I_ACCLIT,
        LMIS_I_STFILE,
        LMIS_I_STIND,
        LMIS_I_STREL,
        LMIS_I_OPTION,
        LMIS_I_RESET,
        LMIS_I_OTHER
    } lmis_instr_e;

    // Pointer update code
    typedef enum {
        LMIS_M_PREINC,
        LMIS_M_PREDEC,
        LMIS_M_POSTINC,
        LMIS_M_POSTDEC
    } lmis_mode_e;

    typedef logic [15:0] lmis_addr_t;

endpackage : lmis_pkg

//--- core/lmis_ptr_unit.sv
`timescale 1ns/1ps
`default_nettype none

`include "lmis_consts.svh"

module lmis_ptr_unit
    import lmis_pkg::*;
(
    input  wire logic [15:0] ptr_i,
    input  wire logic [1:0]  code_i,
    input  wire logic        rel_i,
    input  wire logic [5:0]  offset_i,
    output logic      [15:0] addr_o,
    output logic      [15:0] ptr_nxt_o
);

    // ------------------------------------------------------------
    // Effective address and pointer update
    // ------------------------------------------------------------
    logic [15:0] inc_w;
    logic [15:0] dec_w;
    logic [15:0] off_w;

    // Wrap modulo 2^16 falls out of the 16-bit width
    assign inc_w = ptr_i + 16'h0001; // RQ9
    assign dec_w = ptr_i - 16'h0001; // RQ9
    assign off_w = ptr_i + {{10{offset_i[5]}}, offset_i}; // RQ7

    // Decode update code into address and new pointer
    always_comb
    begin
        if (rel_i)
        begin
            addr_o    = off_w; // RQ7
            ptr_nxt_o = ptr_i; // RQ7
        end
        else
        begin
            case (code_i)
                2'b00:   begin addr_o = inc_w; ptr_nxt_o = inc_w; end // RQ6
                2'b01:   begin addr_o = dec_w; ptr_nxt_o = dec_w; end // RQ6
                2'b10:   begin addr_o = ptr_i; ptr_nxt_o = inc_w; end // RQ8
                default: begin addr_o = ptr_i; ptr_nxt_o = dec_w; end // RQ8
            endcase
        end
    end

endmodule : lmis_ptr_unit

`default_nettype wire

//--- core/lmis_core.sv
// Operation
// RQ1: Load-bank-literal writes its 5-bit operand into the bank select register, flags untouched.
// RQ2: Load-page-literal writes its 7-bit operand into the program counter high latch, flags untouched.
// RQ3: Load-acc-literal places its 8-bit value in the accumulator in one cycle, flags untouched.
// RQ4: Store-acc-file copies the accumulator to file address 0..127 in one cycle, flags untouched.
// RQ5: Store-acc-indirect writes the accumulator to the location the chosen pointer addresses; the window register redirects.
// RQ6: Update code 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec; pre-modes use the updated pointer.
// RQ7: Relative form addresses pointer plus signed offset -32..31 and leaves the pointer unchanged.
// RQ8: Increments leave old plus one, decrements old minus one; post-modes access the old value.
// RQ9: The pointer is 16 bits and wraps modulo 0000h..FFFFh.
// RQ10: Pointer updates never touch any status flag.
// RQ11: Load-options copies the accumulator to the options register, flags untouched.
// RQ12: Software reset requests a full device reset and clears the software reset flag.
// RQ13: No-operation takes one cycle and changes nothing but the program counter.
`timescale 1ns/1ps
`default_nettype none

`include "lmis_consts.svh"

module lmis_core
    import lmis_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        instr_valid_i,
    input  wire logic [13:0] instr_i,
    input  wire logic [2:0]  status_i,
    input  wire logic        swflag_set_i,
    output logic      [7:0]  acc_o,
    output logic      [4:0]  bank_select_o,
    output logic      [6:0]  program_counter_high_latch_o,
    output logic      [7:0]  option_o,
    output logic      [15:0] indirect_pointer0_o,
    output logic      [15:0] indirect_pointer1_o,
    output logic      [2:0]  status_o,
    output logic             software_reset_flag_o,
    output logic             mem_we_o,
    output logic      [15:0] mem_addr_o,
    output logic      [7:0]  mem_wdata_o,
    output logic             file_we_o,
    output logic      [6:0]  file_addr_o,
    output logic             pc_adv_o,
    output logic             dev_reset_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  acc;
        logic [4:0]  bank;
        logic [6:0]  page;
        logic [7:0]  option;
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        logic [2:0]  status;
        logic        swflag;
        logic        mem_we;
        logic [15:0] mem_addr;
        logic [7:0]  mem_wdata;
        logic        file_we;
        logic [6:0]  file_addr;
        logic        pc_adv;
        logic        dev_reset;
    } lmis_state_s;

    lmis_state_s st_r;
    lmis_state_s st_nxt;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic lmis_instr_e lmis_decode(input logic [13:0] w);
        lmis_instr_e c;
        c = LMIS_I_OTHER;
        if (w == `LMIS_OP_NOP)
            c = LMIS_I_NOP;
        else if (w == `LMIS_OP_RESET)
            c = LMIS_I_RESET;
        else if (w == `LMIS_OP_OPTION)
            c = LMIS_I_OPTION;
        else if ((w & `LMIS_MSK_BANK) == `LMIS_PAT_BANK)
            c = LMIS_I_BANK;
        else if ((w & `LMIS_MSK_PAGE) == `LMIS_PAT_PAGE)
            c = LMIS_I_PAGE;
        else if ((w & `LMIS_MSK_ACCLIT) == `LMIS_PAT_ACCLIT)
            c = LMIS_I_ACCLIT;
        else if ((w & `LMIS_MSK_STFILE) == `LMIS_PAT_STFILE)
            c = LMIS_I_STFILE;
        else if ((w & `LMIS_MSK_INDMODE) == `LMIS_PAT_INDMODE)
            c = LMIS_I_STIND;
        else if ((w & `LMIS_MSK_INDREL) == `LMIS_PAT_INDREL)
            c = LMIS_I_STREL;
        return c;
    endfunction : lmis_decode

    lmis_instr_e cls_w;
    logic        sel_w;
    logic [15:0] sel_ptr_w;
    logic [15:0] eff_addr_w;
    logic [15:0] ptr_upd_w;

    assign cls_w     = lmis_decode(instr_i);
    assign sel_w     = (cls_w == LMIS_I_STREL) ? instr_i[`LMIS_SEL_REL_BIT]
                                               : instr_i[`LMIS_SEL_MODE_BIT];
    assign sel_ptr_w = sel_w ? st_r.ptr1 : st_r.ptr0;

    // Pointer arithmetic
    lmis_ptr_unit u_ptr (
        .ptr_i     (sel_ptr_w),
        .code_i    (instr_i[1:0]),
        .rel_i     (cls_w == LMIS_I_STREL),
        .offset_i  (instr_i[5:0]),
        .addr_o    (eff_addr_w),
        .ptr_nxt_o (ptr_upd_w)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt           = st_r;
        st_nxt.mem_we    = 1'b0;
        st_nxt.file_we   = 1'b0;
        st_nxt.pc_adv    = 1'b0;
        st_nxt.dev_reset = 1'b0;
        st_nxt.status    = status_i; // Flags owned elsewhere; no op here alters them
        if (instr_valid_i)
        begin
            st_nxt.pc_adv = 1'b1; // RQ13
            case (cls_w)
                LMIS_I_NOP:    st_nxt.pc_adv = 1'b1; // RQ13
                LMIS_I_BANK:   st_nxt.bank = instr_i[4:0]; // RQ1
                LMIS_I_PAGE:   st_nxt.page = instr_i[6:0]; // RQ2
                LMIS_I_ACCLIT: st_nxt.acc = instr_i[7:0]; // RQ3
                LMIS_I_OPTION: st_nxt.option = st_r.acc; // RQ11
                LMIS_I_STFILE:
                begin
                    // Window address redirects through the pointer
                    if (instr_i[6:0] == `LMIS_FILE_IND0 || instr_i[6:0] == `LMIS_FILE_IND1)
                    begin
                        st_nxt.mem_we    = 1'b1; // RQ5
                        st_nxt.mem_addr  = instr_i[0] ? st_r.ptr1 : st_r.ptr0; // RQ5
                        st_nxt.mem_wdata = st_r.acc;
                    end
                    else
                    begin
                        st_nxt.file_we   = 1'b1; // RQ4
                        st_nxt.file_addr = instr_i[6:0]; // RQ4
                        st_nxt.mem_wdata = st_r.acc; // RQ4
                    end
                end
                LMIS_I_STIND, LMIS_I_STREL:
                begin
                    st_nxt.mem_we    = 1'b1; // RQ5
                    st_nxt.mem_addr  = eff_addr_w; // RQ6
                    st_nxt.mem_wdata = st_r.acc; // RQ5
                    // Pointer write leaves status untouched
                    if (sel_w)
                        st_nxt.ptr1 = ptr_upd_w; // RQ10
                    else
                        st_nxt.ptr0 = ptr_upd_w; // RQ10
                end
                LMIS_I_RESET:
                begin
                    st_nxt.dev_reset = 1'b1; // RQ12
                    st_nxt.swflag    = 1'b0; // RQ12
                    st_nxt.pc_adv    = 1'b0;
                end
                default: st_nxt.pc_adv = 1'b1;
            endcase
        end
        // Set request wins over a clear by the reset instruction in the same cycle
        if (swflag_set_i)
            st_nxt.swflag = 1'b1;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_r.acc       <= `LMIS_RST_ACC;
            st_r.bank      <= `LMIS_RST_BANK;
            st_r.page      <= `LMIS_RST_PAGE;
            st_r.option    <= `LMIS_RST_OPTION;
            st_r.ptr0      <= `LMIS_RST_PTR;
            st_r.ptr1      <= `LMIS_RST_PTR;
            st_r.status    <= `LMIS_RST_STATUS;
            st_r.swflag    <= `LMIS_RST_SWFLAG;
            st_r.mem_we    <= `LMIS_RST_PULSE;
            st_r.mem_addr  <= `LMIS_RST_PTR;
            st_r.mem_wdata <= `LMIS_RST_ACC;
            st_r.file_we   <= `LMIS_RST_PULSE;
            st_r.file_addr <= `LMIS_RST_PAGE;
            st_r.pc_adv    <= `LMIS_RST_PULSE;
            st_r.dev_reset <= `LMIS_RST_PULSE;
        end
        else if (ce_i)
        begin
            st_r <= st_nxt;
        end
    end

    assign acc_o                        = st_r.acc;
    assign bank_select_o                = st_r.bank;
    assign program_counter_high_latch_o = st_r.page;
    assign option_o                     = st_r.option;
    assign indirect_pointer0_o          = st_r.ptr0;
    assign indirect_pointer1_o          = st_r.ptr1;
    assign status_o                     = st_r.status;
    assign software_reset_flag_o        = st_r.swflag;
    assign mem_we_o                     = st_r.mem_we;
    assign mem_addr_o                   = st_r.mem_addr;
    assign mem_wdata_o                  = st_r.mem_wdata;
    assign file_we_o                    = st_r.file_we;
    assign file_addr_o                  = st_r.file_addr;
    assign pc_adv_o                     = st_r.pc_adv;
    assign dev_reset_o                  = st_r.dev_reset;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_bank_load: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
        ce_i && instr_valid_i && cls_w == LMIS_I_BANK |=> bank_select_o == $past(instr_i[4:0]))
        else $error("bank select not loaded");
    a_page_load: assert property (@(posedge clk_i) disable iff (rst_i) // RQ2
        ce_i && instr_valid_i && cls_w == LMIS_I_PAGE
        |=> program_counter_high_latch_o == $past(instr_i[6:0]))
        else $error("page latch not loaded");
    a_acc_load: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
        ce_i && instr_valid_i && cls_w == LMIS_I_ACCLIT |=> acc_o == $past(instr_i[7:0]))
        else $error("accumulator not loaded");
    a_file_store: assert property (@(posedge clk_i) disable iff (rst_i) // RQ4
        ce_i && instr_valid_i && cls_w == LMIS_I_STFILE && instr_i[6:1] != 6'h00
        |=> file_we_o && file_addr_o == $past(instr_i[6:0]) && mem_wdata_o == $past(acc_o))
        else $error("file store wrong");
    a_ind_store: assert property (@(posedge clk_i) disable iff (rst_i) // RQ5
        ce_i && instr_valid_i && cls_w == LMIS_I_STIND
        |=> mem_we_o && mem_wdata_o == $past(acc_o))
        else $error("indirect store missing");
    a_preinc_addr: assert property (@(posedge clk_i) disable iff (rst_i) // RQ6
        ce_i && instr_valid_i && cls_w == LMIS_I_STIND && instr_i[2:0] == 3'b000
        |=> mem_addr_o == $past(indirect_pointer0_o) + 16'h0001
            && indirect_pointer0_o == mem_addr_o)
        else $error("pre-increment address wrong");
    a_rel_keep: assert property (@(posedge clk_i) disable iff (rst_i) // RQ7
        ce_i && instr_valid_i && cls_w == LMIS_I_STREL
        |=> $stable(indirect_pointer0_o) && $stable(indirect_pointer1_o))
        else $error("relative move changed pointer");
    a_postdec_ptr: assert property (@(posedge clk_i) disable iff (rst_i) // RQ8
        ce_i && instr_valid_i && cls_w == LMIS_I_STIND && instr_i[2:0] == 3'b111
        |=> mem_addr_o == $past(indirect_pointer1_o)
            && indirect_pointer1_o == $past(indirect_pointer1_o) - 16'h0001)
        else $error("post-decrement wrong");
    a_opt_load: assert property (@(posedge clk_i) disable iff (rst_i) // RQ11
        ce_i && instr_valid_i && cls_w == LMIS_I_OPTION |=> option_o == $past(acc_o))
        else $error("options not loaded");
    a_soft_reset: assert property (@(posedge clk_i) disable iff (rst_i) // RQ12
        ce_i && instr_valid_i && cls_w == LMIS_I_RESET && !swflag_set_i
        |=> dev_reset_o && !software_reset_flag_o ##1 !dev_reset_o || !$past(ce_i))
        else $error("software reset wrong");
    a_nop_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // RQ13
        ce_i && instr_valid_i && cls_w == LMIS_I_NOP
        |=> pc_adv_o && !mem_we_o && !file_we_o && $stable(acc_o))
        else $error("nop changed state");
    a_status_keep: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
        ce_i |=> status_o == $past(status_i))
        else $error("status flags altered");
    a_flag_set: assert property (@(posedge clk_i) disable iff (rst_i) // RQ12
        ce_i && swflag_set_i |=> software_reset_flag_o)
        else $error("software reset flag set lost");

endmodule : lmis_core

`default_nettype wire

//--- verif/test_literal_move_indirect_store_ops.sv
`timescale 1ns/1ps
`default_nettype none

module test_literal_move_indirect_store_ops
    import lmis_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        clk_i;
    logic        rst_i;
    logic        ce_i;
    logic        instr_valid_i;
    logic [13:0] instr_i;
    logic [2:0]  status_i;
    logic        swflag_set_i;
    logic [7:0]  acc_o;
    logic [4:0]  bank_select_o;
    logic [6:0]  program_counter_high_latch_o;
    logic [7:0]  option_o;
    logic [15:0] indirect_pointer0_o;
    logic [15:0] indirect_pointer1_o;
    logic [2:0]  status_o;
    logic        software_reset_flag_o;
    logic        mem_we_o;
    logic [15:0] mem_addr_o;
    logic [7:0]  mem_wdata_o;
    logic        file_we_o;
    logic [6:0]  file_addr_o;
    logic        pc_adv_o;
    logic        dev_reset_o;
    logic [15:0] e_ptr [2];
    logic [7:0]  e_acc;
    int          error_cnt = 0;
    int          n_tests   = 0;
    int          cyc       = 0;

    lmis_core DUT (
        .clk_i                        (clk_i),
        .rst_i                        (rst_i),
        .ce_i                         (ce_i),
        .instr_valid_i                (instr_valid_i),
        .instr_i                      (instr_i),
        .status_i                     (status_i),
        .swflag_set_i                 (swflag_set_i),
        .acc_o                        (acc_o),
        .bank_select_o                (bank_select_o),
        .program_counter_high_latch_o (program_counter_high_latch_o),
        .option_o                     (option_o),
        .indirect_pointer0_o          (indirect_pointer0_o),
        .indirect_pointer1_o          (indirect_pointer1_o),
        .status_o                     (status_o),
        .software_reset_flag_o        (software_reset_flag_o),
        .mem_we_o                     (mem_we_o),
        .mem_addr_o                   (mem_addr_o),
        .mem_wdata_o                  (mem_wdata_o),
        .file_we_o                    (file_we_o),
        .file_addr_o                  (file_addr_o),
        .pc_adv_o                     (pc_adv_o),
        .dev_reset_o                  (dev_reset_o)
    );

    // Free running clock, 20 ns period
    always #10 clk_i = ~clk_i;

    // Hang guard
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            error_cnt++;
            test_done();
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    // Compare one value
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Pulses {pc_adv, mem_we, file_we} and untouched status
    task automatic pulses(input logic [2:0] p);
        chk(16'({pc_adv_o, mem_we_o, file_we_o}), 16'(p));
        chk(16'(status_o), 16'(status_i));
    endtask : pulses

    // Present one instruction, taken at the next edge
    task automatic exec(input logic [13:0] w);
        @(posedge clk_i);
        instr_i       <= w;
        instr_valid_i <= 1'b1;
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        #1;
    endtask : exec

    // Reset and check the reset state
    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        e_ptr[0] = 16'h0000;
        e_ptr[1] = 16'h0000;
        e_acc    = 8'h00;
        chk({acc_o, 3'b000, bank_select_o}, 16'h0000);
        chk({1'b0, program_counter_high_latch_o, option_o}, 16'h00FF);
        chk(indirect_pointer0_o | indirect_pointer1_o, 16'h0000);
        chk(16'({software_reset_flag_o, pc_adv_o, mem_we_o, dev_reset_o}), 16'h0008);
    endtask : do_reset

    // Indirect store with an update code
    task automatic ind(input logic n, input logic [1:0] mm);
        logic [15:0] old;
        logic [15:0] nw;
        old = e_ptr[n];
        nw  = mm[0] ? old - 16'h0001 : old + 16'h0001;
        exec(14'h0018 | 14'({n, mm}));
        e_ptr[n] = nw;
        chk(mem_addr_o, mm[1] ? old : nw);
        chk(n ? indirect_pointer1_o : indirect_pointer0_o, nw);
        chk(16'(mem_wdata_o), 16'(e_acc));
        pulses(3'b110);
    endtask : ind

    // Relative store with a signed offset
    task automatic rel(input logic n, input logic [5:0] k);
        exec(14'h3F80 | 14'({n, k}));
        chk(mem_addr_o, e_ptr[n] + {{10{k[5]}}, k});
        chk(n ? indirect_pointer1_o : indirect_pointer0_o, e_ptr[n]);
        pulses(3'b110);
    endtask : rel

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        clk_i         = 1'b0;
        rst_i         = 1'b1;
        ce_i          = 1'b1;
        instr_valid_i = 1'b0;
        instr_i       = 14'h0000;
        status_i      = 3'b101;
        swflag_set_i  = 1'b0;
        do_reset();
        // Literal loads over every operand value
        for (int i = 0; i < 32; i++)
        begin
            exec(14'h0020 | 14'(i));
            chk(16'(bank_select_o), 16'(i));
            pulses(3'b100);
        end
        for (int i = 0; i < 128; i++)
        begin
            exec(14'h3180 | 14'(i));
            chk(16'(program_counter_high_latch_o), 16'(i));
            pulses(3'b100);
        end
        for (int i = 0; i < 256; i++)
        begin
            exec(14'h3000 | 14'(i));
            chk(16'(acc_o), 16'(i));
            pulses(3'b100);
        end
        exec(14'h3000 | 14'h004F);
        e_acc = 8'h4F;
        // Direct stores to file addresses above the windows
        for (int i = 2; i < 128; i++)
        begin
            exec(14'h0080 | 14'(i));
            chk({1'b0, file_addr_o, mem_wdata_o}, 16'((i << 8) | 8'h4F));
            pulses(3'b101);
        end
        @(posedge clk_i);
        status_i <= 3'b010;
        // Every update code on both pointers, wrap both ways on pointer 0, then relative stores
        for (int n = 0; n < 2; n++)
            for (int m = 0; m < 4; m++)
                ind(n[0], m[1:0]);
        ind(1'b0, 2'b01);
        ind(1'b0, 2'b00);
        ind(1'b0, 2'b11);
        ind(1'b0, 2'b10);
        ind(1'b1, 2'b10);
        ind(1'b1, 2'b10);
        rel(1'b1, 6'h20);
        rel(1'b1, 6'h1F);
        rel(1'b0, 6'h3F);
        // Store to a window goes through its pointer
        exec(14'h0081);
        chk(mem_addr_o, e_ptr[1]);
        pulses(3'b110);
        exec(14'h0080);
        chk(mem_addr_o, e_ptr[0]);
        // Options load and no-operation
        exec(14'h0062);
        chk(16'(option_o), 16'h004F);
        pulses(3'b100);
        exec(14'h0000);
        chk({acc_o, option_o}, 16'h4F4F);
        chk(indirect_pointer1_o, e_ptr[1]);
        chk(16'({dev_reset_o, bank_select_o}), 16'h001F);
        pulses(3'b100);
        // Unknown opcode only advances the program counter
        exec(14'h0100);
        chk(16'(acc_o), 16'h004F);
        pulses(3'b100);
        // Disabled clock freezes state
        @(posedge clk_i);
        ce_i <= 1'b0;
        exec(14'h3011);
        chk(16'(acc_o), 16'h004F);
        pulses(3'b000);
        @(posedge clk_i);
        ce_i <= 1'b1;
        // Software reset request and flag
        exec(14'h0001);
        chk(16'({dev_reset_o, software_reset_flag_o}), 16'h0002);
        pulses(3'b000);
        @(posedge clk_i);
        swflag_set_i <= 1'b1;
        @(posedge clk_i);
        swflag_set_i <= 1'b0;
        #1;
        chk(16'({dev_reset_o, software_reset_flag_o}), 16'h0001);
        // Set request in the same cycle as the reset instruction wins
        @(posedge clk_i);
        swflag_set_i  <= 1'b1;
        instr_i       <= 14'h0001;
        instr_valid_i <= 1'b1;
        @(posedge clk_i);
        swflag_set_i  <= 1'b0;
        instr_valid_i <= 1'b0;
        #1;
        chk(16'({dev_reset_o, software_reset_flag_o}), 16'h0003);
        do_reset();
        test_done();
    end

endmodule : test_literal_move_indirect_store_ops

`default_nettype wire
